/* File: rtl/crs_pkg.sv */
/*
  Constants, register map and types of the clock, reset and standby
  controller.
  Assumes one 200 MHz system clock. The oscillators arrive as one-cycle
  tick enables on that clock.
*/
// Contract
// - While reset is low all state is cleared; after release fetch starts at 0040H.
// - During reset port 2 bit 1 is driven high, and a low strap there enters test mode.
// - A low stop pin while the arming bit is 1 enters hardware stop and halts the fast oscillator.
// - The clock output gives the fast clock over 2 or 4, or the slow clock over 2 or 4.
// - The CPU clock is the fast clock, half the fast clock, or the slow clock.
// - A 14-bit time-base counter counts the CPU clock divided by 4n, n from 1 to 8.
// - The watch timer always counts the 32.768 kHz slow clock.
package crs_pkg;
  localparam logic [15:0] crs_reset_vector = 16'h0040;
  localparam int crs_tbc_width = 14;
  localparam int crs_tbc_div_max = 8;
  localparam int crs_tbc_base_div = 4;
  localparam int crs_watch_width = 15;
  localparam real crs_slow_khz = 32.768;
  // register offsets, byte addresses on a 32-bit bus
  localparam logic [3:0] crs_off_standby = 4'h0;
  localparam logic [3:0] crs_off_clock = 4'h4;
  localparam logic [3:0] crs_off_status = 4'h8;
  localparam logic [3:0] crs_off_tbc = 4'hC;
  // standby_control_register fields
  localparam int crs_arm_pos = 0;
  // clock register fields
  localparam int crs_cpu_sel_lsb = 0;
  localparam int crs_out_sel_lsb = 2;
  localparam int crs_out_en_pos = 4;
  localparam int crs_tbc_n_lsb = 8;
  // status fields
  localparam int crs_st_stop_pos = 0;
  localparam int crs_st_test_pos = 1;
  localparam logic [31:0] crs_clock_reset = 32'h0000_0000;

  typedef enum logic [1:0] {
    crs_cpu_fast, crs_cpu_half, crs_cpu_slow, crs_cpu_rsvd
  } crs_cpu_sel_t;
  typedef enum logic [1:0] {
    crs_out_fast2, crs_out_fast4, crs_out_slow2, crs_out_slow4
  } crs_out_sel_t;
  typedef enum logic [1:0] {crs_st_reset, crs_st_run, crs_st_stop, crs_st_test}
    crs_mode_t;
endpackage : crs_pkg

/* File: rtl/crs_div_if.sv */
/*
  Interface carrying a tick divider's input and output.
  Assumes both ends sit on the one system clock.
*/
`timescale 1ns/10ps
interface crs_div_if;
  logic tick_in;
  logic [3:0] ratio_m1;
  logic tick_out;
  logic phase;
  modport ctl (output tick_in, output ratio_m1, input tick_out, input phase);
  modport div (input tick_in, input ratio_m1, output tick_out, output phase);
endinterface : crs_div_if

/* File: rtl/crs_tick_div.sv */
/*
  Tick divider: passes one tick out of every ratio_m1+1 ticks in and
  toggles a square-wave phase on each output tick.
  Assumes ticks are one-cycle enables on the system clock.
*/
`timescale 1ns/10ps
module crs_tick_div
  import crs_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  crs_div_if.div d
);
  typedef struct packed {
    logic [3:0] cnt;
    logic phase;
  } crs_div_state_t;
  crs_div_state_t st, next_st;
  logic hit;

  assign hit = d.tick_in && (st.cnt >= d.ratio_m1);
  assign d.tick_out = hit && run;
  assign d.phase = st.phase;

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st = '0;
    end else if (d.tick_in) begin
      next_st.cnt = hit ? 4'h0 : st.cnt + 4'h1;
      if (hit) begin
        next_st.phase = ~st.phase;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : crs_tick_div

/* File: rtl/crs_ctrl.sv */
/*
  Clock, reset and standby controller with a classic Wishbone slave.
  Assumes fast_tick and slow_tick are one-cycle enables marking the
  fast and 32.768 kHz oscillator edges, synchronous to clock.
*/
`timescale 1ns/10ps
module crs_ctrl
  import crs_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic hw_stop_request_pin_n,
  input wire logic port2_bit1_strap_in,
  output logic port2_bit1_strap_out,
  output logic port2_bit1_strap_oe_n,
  output logic fast_osc_enable,
  output logic cpu_clk_tick,
  output logic cpu_run,
  output logic test_mode,
  output logic [15:0] fetch_address,
  output logic tbc_tick,
  output logic [13:0] tbc_count,
  output logic watch_tick,
  output logic [14:0] watch_count,
  output logic divided_clock_output_pin,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  typedef struct packed {
    crs_mode_t mode;
    logic strap_seen;
    logic hw_stop_arm_bit;
    crs_cpu_sel_t cpu_sel;
    crs_out_sel_t out_sel;
    logic out_en;
    logic [2:0] tbc_n_m1;
    logic half_ph;
    logic [1:0] q4;
    logic [13:0] tbc;
    logic [14:0] watch;
    logic out_pin;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } crs_state_t;
  crs_state_t st, next_st;

  // elaboration-time refusal of a geometry the dividers cannot serve
  if (crs_tbc_width != 14 || crs_tbc_div_max != 8) begin : g_bad_geometry
    $error("time-base counter geometry unsupported");
  end

  logic running;
  logic cpu_raw;
  logic access;
  logic [31:0] clock_reg;
  crs_div_if tbc_if ();

  assign running = (st.mode == crs_st_run);
  always_comb begin
    case (st.cpu_sel)
      crs_cpu_fast: cpu_raw = fast_tick && fast_osc_enable;
      crs_cpu_half: cpu_raw = fast_tick && fast_osc_enable && st.half_ph;
      crs_cpu_slow: cpu_raw = slow_tick;
      default: cpu_raw = fast_tick && fast_osc_enable;
    endcase
  end
  assign cpu_clk_tick = cpu_raw && running;

  // quarter of cpu clock, then the 1/n stage
  assign tbc_if.tick_in = cpu_clk_tick && (st.q4 == 2'(crs_tbc_base_div - 1));
  assign tbc_if.ratio_m1 = {1'b0, st.tbc_n_m1};
  crs_tick_div u_tbc_div (
    .clock(clock),
    .nrst(nrst),
    .run(running),
    .d(tbc_if.div)
  );
  assign tbc_tick = tbc_if.tick_out;
  assign tbc_count = st.tbc;
  assign watch_tick = slow_tick;
  assign watch_count = st.watch;

  assign fast_osc_enable = (st.mode != crs_st_stop);
  assign cpu_run = running;
  assign test_mode = (st.mode == crs_st_test);
  assign fetch_address = crs_reset_vector;
  // strap driven high while reset is in progress, released afterwards
  assign port2_bit1_strap_out = 1'b1;
  assign port2_bit1_strap_oe_n = (st.mode != crs_st_reset);
  assign divided_clock_output_pin = st.out_pin;
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign wb_err_o = st.err;
  assign access = wb_cyc_i && wb_stb_i && !st.ack && !st.err;

  always_comb begin
    clock_reg = crs_clock_reset;
    clock_reg[crs_cpu_sel_lsb +: 2] = st.cpu_sel;
    clock_reg[crs_out_sel_lsb +: 2] = st.out_sel;
    clock_reg[crs_out_en_pos] = st.out_en;
    clock_reg[crs_tbc_n_lsb +: 3] = st.tbc_n_m1;
  end

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    case (st.mode)
      // one cycle after release the strap is sampled, still driven high
      crs_st_reset: begin
        next_st.mode = port2_bit1_strap_in ? crs_st_run : crs_st_test;
      end
      crs_st_run: begin
        if (!hw_stop_request_pin_n && st.hw_stop_arm_bit) begin
          next_st.mode = crs_st_stop;
        end
      end
      // leaving stop needs a reset: no wake source lives here
      crs_st_stop: next_st.mode = crs_st_stop;
      crs_st_test: next_st.mode = crs_st_test;
      default: next_st.mode = crs_st_reset;
    endcase
    if (fast_tick && fast_osc_enable) begin
      next_st.half_ph = ~st.half_ph;
    end
    if (cpu_clk_tick) begin
      next_st.q4 = st.q4 + 2'h1;
    end
    if (tbc_if.tick_out) begin
      next_st.tbc = st.tbc + 14'h1;
    end
    if (slow_tick) begin
      next_st.watch = st.watch + 15'h1;
    end
    // clock output pin, square wave at tick/2 or tick/4
    if (!st.out_en) begin
      next_st.out_pin = 1'b0;
    end else begin
      case (st.out_sel)
        crs_out_fast2: begin
          if (fast_tick && fast_osc_enable) next_st.out_pin = ~st.out_pin;
        end
        crs_out_fast4: begin
          if (fast_tick && fast_osc_enable && st.half_ph)
            next_st.out_pin = ~st.out_pin;
        end
        crs_out_slow2: begin
          if (slow_tick) next_st.out_pin = ~st.out_pin;
        end
        crs_out_slow4: begin
          if (slow_tick && st.watch[0]) next_st.out_pin = ~st.out_pin;
        end
        default: next_st.out_pin = 1'b0;
      endcase
    end
    if (access) begin
      next_st.ack = 1'b1;
      next_st.rdata = '0;
      case (wb_adr_i)
        crs_off_standby: begin
          next_st.rdata[crs_arm_pos] = st.hw_stop_arm_bit;
          if (wb_we_i && wb_sel_i[0])
            next_st.hw_stop_arm_bit = wb_dat_i[crs_arm_pos];
        end
        crs_off_clock: begin
          next_st.rdata = clock_reg;
          if (wb_we_i && wb_sel_i[0]) begin
            next_st.cpu_sel = crs_cpu_sel_t'(wb_dat_i[crs_cpu_sel_lsb +: 2]);
            next_st.out_sel = crs_out_sel_t'(wb_dat_i[crs_out_sel_lsb +: 2]);
            next_st.out_en = wb_dat_i[crs_out_en_pos];
          end
          if (wb_we_i && wb_sel_i[1])
            next_st.tbc_n_m1 = wb_dat_i[crs_tbc_n_lsb +: 3];
        end
        crs_off_status: begin
          next_st.rdata[crs_st_stop_pos] = (st.mode == crs_st_stop);
          next_st.rdata[crs_st_test_pos] = (st.mode == crs_st_test);
        end
        crs_off_tbc: begin
          next_st.rdata[crs_tbc_width-1:0] = st.tbc;
          if (wb_we_i && wb_sel_i[0]) next_st.tbc = '0;
        end
        default: begin
          next_st.ack = 1'b0;
          next_st.err = 1'b1;
        end
      endcase
    end
  end

  // every field cleared while nrst is low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : crs_ctrl

/* File: verification/crs_ctrl_monitor.sv */
/* Port checker of crs_ctrl.
   Assumes a bind by port name. */
`timescale 1ns/10ps
module crs_mon (
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow_tick,
  input wire logic hw_stop_request_pin_n,
  input wire logic port2_bit1_strap_in,
  input wire logic port2_bit1_strap_oe_n,
  input wire logic fast_osc_enable,
  input wire logic cpu_clk_tick,
  input wire logic cpu_run,
  input wire logic test_mode,
  input wire logic [15:0] fetch_address,
  input wire logic tbc_tick,
  input wire logic watch_tick
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_FETCH: assert property (fetch_address == 16'h0040)
    else $error("fetch");
  AST_STRAP: assert property ($rose(nrst) |-> !port2_bit1_strap_oe_n)
    else $error("strap");
  AST_TEST: assert property ($rose(nrst) |=>
    test_mode == !$past(port2_bit1_strap_in) && cpu_run != test_mode)
    else $error("test");
  AST_STOP: assert property ($fell(fast_osc_enable) |->
    $past(cpu_run && !hw_stop_request_pin_n)) else $error("stop");
  // stop is left only through reset
  AST_HOLD: assert property (!fast_osc_enable |=> !fast_osc_enable)
    else $error("hold");
  AST_IDLE: assert property (!cpu_run |-> !cpu_clk_tick)
    else $error("idle");
  AST_TBC: assert property (tbc_tick |-> cpu_clk_tick)
    else $error("tbc");
  AST_WATCH: assert property (watch_tick == slow_tick)
    else $error("watch");
endmodule : crs_mon
bind crs_ctrl crs_mon u_mon (.*);

/* File: verification/crs_osc_model.sv */
/* Oscillator ticks and the strap pin.
   Assumes the pin has a pull-up. */
`timescale 1ns/10ps
module crs_osc_model (
  input wire logic clock,
  input wire logic fast_osc_enable,
  input wire logic strap_low,
  input wire logic port2_bit1_strap_out,
  input wire logic port2_bit1_strap_oe_n,
  output logic fast_tick,
  output logic slow_tick,
  output logic port2_bit1_strap_in
);
  logic fc = 1'b0;
  logic [2:0] sc = 3'h0;
  always @(posedge clock) begin
    fc <= fast_osc_enable && !fc;
    sc <= sc == 3'h5 ? 3'h0 : sc + 3'h1;
  end
  assign fast_tick = fc;
  assign slow_tick = sc == 3'h5;
  assign port2_bit1_strap_in = !strap_low &&
    (port2_bit1_strap_oe_n || port2_bit1_strap_out);
endmodule : crs_osc_model

/* File: verification/crs_ctrl_tb.sv */
/* Bench of crs_ctrl.
   Assumes the oscillator model and the bound checker. */
`timescale 1ns/10ps
module crs_ctrl_tb
  import crs_pkg::*;
;
  logic clock = 1'b0, nrst = 1'b0, strap_low = 1'b0;
  logic hw_stop_request_pin_n = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, wb_ack_o, wb_err_o, fast_tick, slow_tick;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic port2_bit1_strap_in, port2_bit1_strap_out, port2_bit1_strap_oe_n;
  logic fast_osc_enable, cpu_clk_tick, cpu_run, test_mode, tbc_tick;
  logic watch_tick, divided_clock_output_pin;
  logic [15:0] fetch_address, c_cpu, c_tbc, c_wat, c_pin;
  logic [13:0] tbc_count, t0, c_cnt;
  logic [14:0] watch_count, w0, c_wct;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0] rnd = 8'h5B;
  int n_errors = 0, checked = 0, cyc = 0;
  int ec[4] = '{24, 12, 8, 24}, ep[4] = '{12, 6, 4, 2};
  crs_ctrl DUT (.*);
  crs_osc_model osc (.*);
  always #2.5 clock = ~clock;
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], ^(v & 8'hB8)};
  endfunction : lfsr
  task automatic chk(input string s, input logic [33:0] x, g);
    checked++;
    if (x !== g) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", s, x, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic er);
    exp_q.push_back({!w, er, d});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (!(wb_ack_o || wb_err_o));
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb
  // long settle lets old divider phases die out first
  task automatic win(input int n);
    logic p;
    repeat (200) @(posedge clock);
    {c_cpu, c_tbc, c_wat, c_pin} = '0;
    t0 = tbc_count;
    w0 = watch_count;
    p = divided_clock_output_pin;
    repeat (n) begin
      @(posedge clock);
      c_cpu += cpu_clk_tick;
      c_tbc += tbc_tick;
      c_wat += watch_tick;
      c_pin += divided_clock_output_pin & !p;
      p = divided_clock_output_pin;
    end
    c_cnt = tbc_count - t0;
    c_wct = watch_count - w0;
  endtask : win
  task automatic rst(input logic low);
    nrst <= 1'b0;
    strap_low <= low;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    strap_low <= 1'b0;
  endtask : rst
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
    if (wb_ack_o || wb_err_o) begin
      e = exp_q.pop_front();
      chk("bus", {e[32], e[33] ? e[31:0] : 32'h0000_0000},
        {wb_err_o, e[33] ? wb_dat_o : 32'h0000_0000});
    end
  end
  initial begin
    rst(1'b0);
    rnd = lfsr(rnd);
    wb(1'b1, {rnd[3:2], 2'b01}, {4{rnd}}, 1'b1);
    wb(1'b0, crs_off_clock, crs_clock_reset, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, crs_off_clock, 32'h0000_0010 | 32'(5 * i), 1'b0);
      win(48);
      chk("cpu", ec[i], c_cpu);
      chk("pin", ep[i], c_pin);
      chk("tbc", ec[i] / 4, c_tbc);
      chk("watch", 16'h0008, c_wat);
      chk("watch_count", 16'h0008, c_wct);
    end
    for (int n = 1; n <= 8; n++) begin
      wb(1'b1, crs_off_clock, 32'((n - 1) << 8), 1'b0);
      win(24 * n);
      chk("tbc", 16'h0003, c_tbc);
      chk("tbc_count", 16'h0003, c_cnt);
    end
    hw_stop_request_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk("unarmed", 1'b1, cpu_run);
    wb(1'b1, crs_off_standby, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge clock);
    wb(1'b0, crs_off_status, 32'h0000_0001, 1'b0);
    hw_stop_request_pin_n <= 1'b1;
    rst(1'b1);
    chk("test", 1'b1, test_mode);
    wb(1'b0, crs_off_status, 32'h0000_0002, 1'b0);
    summarize();
  end
endmodule : crs_ctrl_tb
